// File: common/awsc_consts.vh
// Contract
// RULE1: Areas 0 and 5 decode their 3-bit wait code into 0, 1, 2, 3, 4, 6, 8 or 10 first-cycle waits and reset to the 10-wait code.
// RULE2: Areas 0 and 5 ignore the external wait input in the first cycle at code 000 and honour it for every other code.
// RULE3: Area 0 and 5 burst transfers after the first take 2, 2, 3, 4, 4, 6, 8 or 10 states with the wait input always honoured.
// RULE4: Area 4 inserts 0, 1, 2, 3, 4, 6, 8 or 10 waits for its 3-bit code, resets to the 10-wait code and has no burst pitch.
// RULE5: Area 4 ignores the external wait input at code 000 and honours it for all other codes.
// RULE6: Area 3 with normal memory inserts 0 to 3 waits for its 2-bit code, ignores the wait input at 00 and resets to 3 waits.
// RULE7: Area 3 honours the wait input only for normal memory and ignores it for dynamic, synchronous dynamic or pseudo-static memory.
// RULE8: Area 3 with dynamic, synchronous dynamic or pseudo-static memory takes 1, 1, 2 or 3 cycles of strobe period or latency per code.
// RULE9: Areas 1 and 2 with normal memory share a 2-bit code giving 0 to 3 waits, ignore the wait input at 00 and reset to 3 waits.
// RULE10: Areas 1 and 2 ignore the wait input whenever dynamic or synchronous dynamic memory is configured there.
// RULE11: Areas 1 and 2 with dynamic memory take 1, 1, 2 or 3 cycles of strobe period or latency per shared code.
// RULE12: An external memory whose wait input is honoured holds it asserted to stretch the access and releases it when data is ready.
`ifndef AWSC_CONSTS_VH
`define AWSC_CONSTS_VH

// Register byte offsets.
`define AWSC_OFF_WAIT_CTRL 4'h0
`define AWSC_OFF_MEM_TYPE 4'h4
`define AWSC_OFF_STATUS 4'h8

// Reset values.
`define AWSC_WAIT_CTRL_RST 16'hFFFF
`define AWSC_MEM_TYPE_RST 4'h0

// Wait control field positions (low bit of each field).
`define AWSC_A0_LSB 0
`define AWSC_A12_LSB 3
`define AWSC_A3_LSB 5
`define AWSC_A4_LSB 7
`define AWSC_A5_LSB 10
`define AWSC_A6_LSB 13

// Memory type field positions and codes.
`define AWSC_MT_A3_LSB 0
`define AWSC_MT_A12_LSB 2
`define AWSC_MT_NORMAL 2'h0

// Bus answers.
`define AWSC_RESP_OKAY 2'h0
`define AWSC_RESP_DECERR 2'h3

`endif

// File: hdl/awsc_cycle_timer.v
`default_nettype none

// Counts down the states of one transfer and measures how long it really took.
module awsc_cycle_timer #(
  parameter CW = 4,
  parameter EW = 8
) (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // Control.
  input wire load,
  input wire [CW-1:0] load_val,
  // Status.
  output wire expired,
  output reg [EW-1:0] elapsed_reg
);

  reg [CW-1:0] count_reg;
  reg [CW-1:0] count_next;
  reg [EW-1:0] elapsed_next;

  // A load restarts both the countdown and the measured length.
  always @* begin
    count_next = count_reg;
    elapsed_next = elapsed_reg;
    if (load) begin
      count_next = load_val;
      elapsed_next = {{(EW-1){1'b0}}, 1'b1};
    end else begin
      if (count_reg != {CW{1'b0}}) begin
        count_next = count_reg - {{(CW-1){1'b0}}, 1'b1};
      end
      if (elapsed_reg != {EW{1'b1}}) begin
        elapsed_next = elapsed_reg + {{(EW-1){1'b0}}, 1'b1};
      end
    end
  end

  // State update.
  always @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= {CW{1'b0}};
      elapsed_reg <= {EW{1'b0}};
    end else begin
      count_reg <= count_next;
      elapsed_reg <= elapsed_next;
    end
  end

  assign expired = (count_reg == {CW{1'b0}});

endmodule

`default_nettype wire

// File: hdl/awsc_area_wait_ctrl.v
// Register access over AXI4-Lite and the register addresses were decided locally.
`include "awsc_consts.vh"
`default_nettype none

// Per-area wait-state generator with an AXI4-Lite register slave.
module awsc_area_wait_ctrl #(
  parameter BEAT_W = 2
) (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address.
  input wire awvalid,
  output wire awready,
  input wire [3:0] awaddr,
  // AXI4-Lite write data.
  input wire wvalid,
  output wire wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // AXI4-Lite write response.
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  // AXI4-Lite read address.
  input wire arvalid,
  output wire arready,
  input wire [3:0] araddr,
  // AXI4-Lite read data.
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  // Access request from the bus state machine.
  input wire acc_start,
  input wire [2:0] acc_area,
  input wire [BEAT_W-1:0] acc_beats,
  output wire acc_ready,
  // External wait input, low while the memory wants more time.
  input wire ext_wait_n,
  // Access progress.
  output reg xfer_strobe_reg,
  output reg acc_done_reg,
  output reg wait_honoured_reg,
  // Dynamic memory strobe period or latency for areas 3 and 1-2.
  output reg [1:0] area3_cas_cycles_reg,
  output reg [1:0] area12_cas_cycles_reg
);

  // One-hot access states.
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_FIRST = 3'b010;
  localparam [2:0] ST_BURST = 3'b100;

  // Decodes a 3-bit code into first-cycle wait states.
  function [3:0] waits3;
    input [2:0] code;
    begin
      case (code)
        3'h0: waits3 = 4'h0;
        3'h1: waits3 = 4'h1;
        3'h2: waits3 = 4'h2;
        3'h3: waits3 = 4'h3;
        3'h4: waits3 = 4'h4;
        3'h5: waits3 = 4'h6;
        3'h6: waits3 = 4'h8;
        default: waits3 = 4'hA;
      endcase
    end
  endfunction

  // Decodes a 3-bit code into states per burst transfer.
  function [3:0] pitch3;
    input [2:0] code;
    begin
      case (code)
        3'h0: pitch3 = 4'h2;
        3'h1: pitch3 = 4'h2;
        3'h2: pitch3 = 4'h3;
        3'h3: pitch3 = 4'h4;
        3'h4: pitch3 = 4'h4;
        3'h5: pitch3 = 4'h6;
        3'h6: pitch3 = 4'h8;
        default: pitch3 = 4'hA;
      endcase
    end
  endfunction

  // Decodes a 2-bit code into the dynamic memory period in cycles.
  function [1:0] dyn2;
    input [1:0] code;
    begin
      dyn2 = (code == 2'h0) ? 2'h1 : code;
    end
  endfunction

  // Registers.
  reg [15:0] wait_ctrl_reg;
  reg [3:0] mem_type_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [2:0] area_reg;
  reg [BEAT_W-1:0] beats_left_reg;
  reg [BEAT_W-1:0] beats_left_next;
  reg honour_reg;
  reg honour_next;
  reg burst_pitch_mode_reg;
  reg burst_pitch_mode_next;

  // AXI holding registers.
  reg aw_held_reg;
  reg w_held_reg;
  reg [3:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;

  // Field views of the wait control and memory type registers.
  wire [2:0] a0_code = wait_ctrl_reg[`AWSC_A0_LSB +: 3];
  wire [1:0] a12_code = wait_ctrl_reg[`AWSC_A12_LSB +: 2];
  wire [1:0] a3_code = wait_ctrl_reg[`AWSC_A3_LSB +: 2];
  wire [2:0] a4_code = wait_ctrl_reg[`AWSC_A4_LSB +: 3];
  wire [2:0] a5_code = wait_ctrl_reg[`AWSC_A5_LSB +: 3];
  wire a3_dynamic = (mem_type_reg[`AWSC_MT_A3_LSB +: 2] != `AWSC_MT_NORMAL);
  wire a12_dynamic = (mem_type_reg[`AWSC_MT_A12_LSB +: 2] != `AWSC_MT_NORMAL);

  // Timer interface.
  reg timer_load;
  reg [3:0] timer_val;
  wire timer_expired;
  wire [7:0] last_len;

  awsc_cycle_timer #(
    .CW(4),
    .EW(8)
  ) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(timer_load),
    .load_val(timer_val),
    .expired(timer_expired),
    .elapsed_reg(last_len)
  );

  // First-cycle wait count and wait honour for the requested area.
  reg [3:0] first_waits;
  reg first_honour;
  reg first_has_pitch;
  always @* begin
    first_waits = 4'h0;
    first_honour = 1'b0;
    first_has_pitch = 1'b0;
    case (acc_area)
      3'h0: begin
        first_waits = waits3(a0_code); // [RULE1]
        first_honour = (a0_code != 3'h0); // [RULE2]
        first_has_pitch = 1'b1;
      end
      3'h5: begin
        first_waits = waits3(a5_code); // [RULE1]
        first_honour = (a5_code != 3'h0); // [RULE2]
        first_has_pitch = 1'b1;
      end
      3'h4: begin
        first_waits = waits3(a4_code); // [RULE4]
        first_honour = (a4_code != 3'h0); // [RULE5]
      end
      3'h3: begin
        if (a3_dynamic) begin
          first_waits = {2'h0, dyn2(a3_code)} - 4'h1; // [RULE8]
          first_honour = 1'b0; // [RULE7]
        end else begin
          first_waits = {2'h0, a3_code}; // [RULE6]
          first_honour = (a3_code != 2'h0); // [RULE6] [RULE7]
        end
      end
      3'h1, 3'h2: begin
        if (a12_dynamic) begin
          first_waits = {2'h0, dyn2(a12_code)} - 4'h1; // [RULE11]
          first_honour = 1'b0; // [RULE10]
        end else begin
          first_waits = {2'h0, a12_code}; // [RULE9]
          first_honour = (a12_code != 2'h0); // [RULE9]
        end
      end
      default: begin
        first_waits = 4'h0;
        first_honour = 1'b0;
      end
    endcase
  end

  // Pitch of later burst transfers for the latched area.
  wire [2:0] pitch_code = (area_reg == 3'h5) ? a5_code : a0_code;
  wire [3:0] burst_len = pitch3(pitch_code) - 4'h1; // [RULE3]

  // A transfer ends when its states are used up and no honoured wait holds it.
  wire stretched = honour_reg && !ext_wait_n; // [RULE12]
  wire xfer_end = timer_expired && !stretched;

  assign acc_ready = state_reg[0];

  // Access sequencing.
  always @* begin
    state_next = state_reg;
    beats_left_next = beats_left_reg;
    honour_next = honour_reg;
    burst_pitch_mode_next = burst_pitch_mode_reg;
    timer_load = 1'b0;
    timer_val = 4'h0;
    case (state_reg)
      ST_IDLE: begin
        if (acc_start) begin
          timer_load = 1'b1;
          timer_val = first_waits;
          honour_next = first_honour;
          burst_pitch_mode_next = first_has_pitch;
          beats_left_next = acc_beats;
          state_next = ST_FIRST;
        end
      end
      ST_FIRST, ST_BURST: begin
        if (xfer_end) begin
          if (beats_left_reg == {BEAT_W{1'b0}}) begin
            state_next = ST_IDLE;
          end else begin
            beats_left_next = beats_left_reg - {{(BEAT_W-1){1'b0}}, 1'b1};
            timer_load = 1'b1;
            state_next = ST_BURST;
            if (burst_pitch_mode_reg) begin
              timer_val = burst_len; // [RULE3]
              honour_next = 1'b1; // [RULE3]
            end else begin
              timer_val = first_waits_latched(area_reg);
            end
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Later beats of areas without a pitch repeat the first-cycle timing.
  function [3:0] first_waits_latched;
    input [2:0] area;
    begin
      case (area)
        3'h4: first_waits_latched = waits3(a4_code);
        3'h3: first_waits_latched = a3_dynamic ? {2'h0, dyn2(a3_code)} - 4'h1
                                               : {2'h0, a3_code};
        3'h1, 3'h2: first_waits_latched = a12_dynamic ? {2'h0, dyn2(a12_code)} - 4'h1
                                                      : {2'h0, a12_code};
        default: first_waits_latched = 4'h0;
      endcase
    end
  endfunction

  // Access state and progress outputs.
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      area_reg <= 3'h0;
      beats_left_reg <= {BEAT_W{1'b0}};
      honour_reg <= 1'b0;
      burst_pitch_mode_reg <= 1'b0;
      xfer_strobe_reg <= 1'b0;
      acc_done_reg <= 1'b0;
      wait_honoured_reg <= 1'b0;
      area3_cas_cycles_reg <= 2'h3;
      area12_cas_cycles_reg <= 2'h3;
    end else begin
      state_reg <= state_next;
      beats_left_reg <= beats_left_next;
      honour_reg <= honour_next;
      burst_pitch_mode_reg <= burst_pitch_mode_next;
      if (state_reg[0] && acc_start) begin
        area_reg <= acc_area;
      end
      xfer_strobe_reg <= !state_reg[0] && xfer_end;
      acc_done_reg <= !state_reg[0] && xfer_end && (beats_left_reg == {BEAT_W{1'b0}});
      wait_honoured_reg <= honour_next && (state_next != ST_IDLE);
      area3_cas_cycles_reg <= dyn2(a3_code); // [RULE8]
      area12_cas_cycles_reg <= dyn2(a12_code); // [RULE11]
    end
  end

  // Write channel: address and data are taken in either order.
  assign awready = !aw_held_reg && !bvalid;
  assign wready = !w_held_reg && !bvalid;
  wire do_write = aw_held_reg && w_held_reg && !bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `AWSC_RESP_OKAY;
      wait_ctrl_reg <= `AWSC_WAIT_CTRL_RST; // [RULE1] [RULE4] [RULE6] [RULE9]
      mem_type_reg <= `AWSC_MEM_TYPE_RST;
    end else begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= `AWSC_RESP_OKAY;
        case (aw_addr_reg)
          `AWSC_OFF_WAIT_CTRL: begin
            if (w_strb_reg[0]) begin
              wait_ctrl_reg[7:0] <= w_data_reg[7:0];
            end
            if (w_strb_reg[1]) begin
              wait_ctrl_reg[15:8] <= w_data_reg[15:8];
            end
          end
          `AWSC_OFF_MEM_TYPE: begin
            if (w_strb_reg[0]) begin
              mem_type_reg <= w_data_reg[3:0];
            end
          end
          `AWSC_OFF_STATUS: begin
            bresp <= `AWSC_RESP_OKAY;
          end
          default: begin
            bresp <= `AWSC_RESP_DECERR;
          end
        endcase
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one read at a time, data from a register.
  assign arready = !rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `AWSC_RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp <= `AWSC_RESP_OKAY;
        case (araddr)
          `AWSC_OFF_WAIT_CTRL: rdata <= {16'h0, wait_ctrl_reg};
          `AWSC_OFF_MEM_TYPE: rdata <= {28'h0, mem_type_reg};
          `AWSC_OFF_STATUS: rdata <= {16'h0, last_len, 1'b0, area_reg,
                                      honour_reg, state_reg};
          default: begin
            rdata <= 32'h0;
            rresp <= `AWSC_RESP_DECERR;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// File: verif/awsc_props.sv
`default_nettype none
// Tracks the programmed codes from completed writes and checks the access timing.
module awsc_props (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus.
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [3:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [31:0] wdata,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  // Access port.
  input wire logic acc_start,
  input wire logic [2:0] acc_area,
  input wire logic acc_ready,
  input wire logic ext_wait_n,
  input wire logic xfer_strobe_reg,
  input wire logic acc_done_reg,
  input wire logic wait_honoured_reg,
  input wire logic [1:0] area3_cas_cycles_reg,
  input wire logic [1:0] area12_cas_cycles_reg
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wa_reg;
  logic [15:0] wd_reg;
  logic [15:0] wc_reg;
  logic [3:0] mt_reg;
  logic [2:0] cur_reg;
  logic ign;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Shadow registers follow each write once its response is taken.
  always @(posedge aclk) begin
    if (!aresetn) begin
      wc_reg <= 16'hFFFF;
      mt_reg <= 4'h0;
    end else begin
      if (awvalid && awready) wa_reg <= awaddr;
      if (wvalid && wready) wd_reg <= wdata[15:0];
      if (bvalid && bready && bresp == 2'h0 && wa_reg == 4'h0) wc_reg <= wd_reg;
      if (bvalid && bready && bresp == 2'h0 && wa_reg == 4'h4) mt_reg <= wd_reg[3:0];
      if (acc_start && acc_ready) cur_reg <= acc_area;
    end
  end

  // High when the requested area ignores the wait input in its first transfer.
  always @* begin
    case (acc_area)
      3'h0: ign = wc_reg[2:0] == 3'h0;
      3'h1, 3'h2: ign = wc_reg[4:3] == 2'h0 || mt_reg[3:2] != 2'h0;
      3'h3: ign = wc_reg[6:5] == 2'h0 || mt_reg[1:0] != 2'h0;
      3'h4: ign = wc_reg[9:7] == 3'h0;
      3'h5: ign = wc_reg[12:10] == 3'h0;
      default: ign = 1'b1;
    endcase
  end

  function automatic logic [1:0] cas_f(input logic [1:0] c);
    return (c == 2'h0) ? 2'h1 : c;
  endfunction

  sequence s_start;
    acc_start && acc_ready;
  endsequence
  sequence s_quiet;
    !bvalid [*2];
  endsequence

  a_wait_ignored:
    assert property (s_start ##0 ign |=> !wait_honoured_reg)
    else $error("wait input honoured in an ignoring access");
  a_wait_enabled:
    assert property (s_start ##0 !ign |-> ##[1:2] wait_honoured_reg)
    else $error("wait input not honoured");
  a_burst_honour:
    assert property (xfer_strobe_reg && !acc_done_reg && (cur_reg == 3'h0 || cur_reg == 3'h5)
      |-> ##[0:1] wait_honoured_reg)
    else $error("burst transfer ignores wait input");
  a_stretch_hold:
    assert property (wait_honoured_reg && !ext_wait_n |=> !xfer_strobe_reg)
    else $error("transfer ended while wait held");
  a_cas3_map:
    assert property (s_quiet |-> area3_cas_cycles_reg == cas_f(wc_reg[6:5]))
    else $error("area3 strobe period wrong");
  a_cas12_map:
    assert property (s_quiet |-> area12_cas_cycles_reg == cas_f(wc_reg[4:3]))
    else $error("area12 strobe period wrong");
  a_busy_refuse:
    assert property (s_start |=> !acc_ready)
    else $error("ready while busy");
  a_done_ready:
    assert property (acc_done_reg |-> acc_ready && xfer_strobe_reg)
    else $error("done without strobe or ready");
endmodule

bind awsc_area_wait_ctrl awsc_props awsc_props_i (.*);
`default_nettype wire

// File: verif/awsc_mem_model.sv
`default_nettype none
// Far-side memory that stretches an access by holding its wait output low for a set time.
module awsc_mem_model (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Access seen on the bus.
  input wire logic acc_start,
  input wire logic acc_ready,
  input wire logic [7:0] hold_len,
  // Wait output, low while data is not ready.
  output logic ext_wait_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] left_reg;
  // Loads the hold time when an access begins and counts it down.
  always @(posedge aclk) begin
    if (!aresetn) left_reg <= 8'h00;
    else if (acc_start && acc_ready) left_reg <= hold_len;
    else if (left_reg != 8'h00) left_reg <= left_reg - 8'h01;
  end
  // The pull-up returns the line high once the count runs out.
  assign ext_wait_n = (left_reg == 8'h00);
endmodule
`default_nettype wire

// File: verif/testbench.sv
`default_nettype none
// Drives registers and accesses, and measures transfer lengths in cycles.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, acc_start;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata;
  logic [2:0] acc_area;
  logic [1:0] acc_beats;
  logic [7:0] hold_len;
  wire awready, wready, bvalid, arready, rvalid, acc_ready, ext_wait_n;
  wire xfer_strobe_reg, acc_done_reg, wait_honoured_reg;
  wire [1:0] bresp, rresp, area3_cas_cycles_reg, area12_cas_cycles_reg;
  wire [31:0] rdata;
  int fail_count, check_count;

  awsc_area_wait_ctrl #(.BEAT_W(2)) awsc_area_wait_ctrl_i (.*);
  awsc_mem_model awsc_mem_model_i (.*);

  // The clock runs at 40 MHz.
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  function automatic int wt(input int c);
    return (c < 5) ? c : 2 * c - 4;
  endfunction
  function automatic int pt(input int c);
    return (c < 2) ? 2 : ((c < 4) ? c + 1 : wt(c));
  endfunction

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %0d seen %0d", n, e, s);
    end
  endtask

  task automatic results;
    if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // One write; each channel is released at the edge that takes it.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ad = ad | (awvalid & awready);
      wd = wd | (wvalid & wready);
      @(posedge aclk);
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
    end while (!(ad && wd));
    do @(negedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic hs;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      hs = arready;
      @(posedge aclk);
    end while (hs !== 1'b1);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // Runs one access; f is the cycle of the first strobe, g the last gap between strobes.
  task automatic run(input logic [2:0] ar, input logic [1:0] bt, input logic [7:0] l,
                     output int f, output int g);
    int n, last;
    logic ok;
    f = 0;
    g = 0;
    n = 0;
    last = 0;
    @(posedge aclk);
    acc_area <= ar;
    acc_beats <= bt;
    hold_len <= l;
    acc_start <= 1'b1;
    do begin
      @(negedge aclk);
      ok = acc_ready;
      @(posedge aclk);
    end while (ok !== 1'b1);
    acc_start <= 1'b0;
    do begin
      @(negedge aclk);
      n++;
      if (xfer_strobe_reg === 1'b1) begin
        if (f == 0) f = n;
        else g = n - last;
        last = n;
      end
    end while (acc_done_reg !== 1'b1 && n < 300);
    // An access that never finishes counts as a mismatch.
    if (acc_done_reg !== 1'b1) fail_count++;
  endtask

  // A hang counts as a mismatch.
  initial begin
    repeat (30000) @(posedge aclk);
    fail_count++;
    results();
  end

  // Reset values, bus answers, then every code of every area.
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int f, g, f1, f2, w, v, k, m;
    static int ar[5] = '{0, 1, 3, 4, 5};
    static int ls[5] = '{0, 3, 5, 7, 10};
    {awvalid, wvalid, bready, arvalid, rready, acc_start} = 6'h00;
    {awaddr, araddr, wdata, acc_area, acc_beats, hold_len} = 53'h0;
    wstrb = 4'hF;
    aresetn = 1'b0;
    fail_count = 0;
    check_count = 0;
    void'($urandom(55));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(4'h0, d, r);
    chk("wait_ctrl", d, 32'h0000FFFF);
    chk("cas3_rst", area3_cas_cycles_reg, 32'h3);
    chk("cas12_rst", area12_cas_cycles_reg, 32'h3);
    axi_rd(4'hC, d, r);
    chk("rresp", r, 32'h3);
    axi_wr(4'hC, 32'h0, r);
    chk("bresp", r, 32'h3);
    run(3'h5, 2'h0, 8'h00, f, g);
    chk("a5_rst_len", f, 32'hC);
    for (int i = 0; i < 5; i++) begin
      m = (i == 1 || i == 2) ? 3 : 7;
      for (int c = 0; c <= m; c++) begin
        v = ($urandom & 32'hFFFF & ~(m << ls[i])) | (c << ls[i]);
        axi_wr(4'h0, v, r);
        axi_rd(4'h0, d, r);
        chk("wait_rb", d, v & 32'hFFFF);
        w = wt(c);
        k = 3 + $urandom % 4;
        run(ar[i], 2'h2, 8'h00, f, g);
        chk("first_len", f, w + 2);
        chk("burst_gap", g, (i == 0 || i == 4) ? pt(c) : w + 1);
        run(ar[i], 2'h0, w + 3, f1, g);
        run(ar[i], 2'h0, w + 3 + k, f2, g);
        chk("stretch", f2 - f1, (c == 0) ? 0 : k);
      end
    end
    for (int i = 1; i < 3; i++) begin
      for (int c = 0; c < 4; c++) begin
        axi_wr(4'h0, c << ls[i], r);
        v = (1 + $urandom % 3) << ((i == 1) ? 2 : 0);
        axi_wr(4'h4, v, r);
        axi_rd(4'h4, d, r);
        chk("mem_type", d, v);
        // Area 2 stands in for the shared pair here; area 1 ran above.
        run((i == 1) ? 3'h2 : 3'h3, 2'h0, 8'h01, f1, g);
        run((i == 1) ? 3'h2 : 3'h3, 2'h0, 8'h09, f2, g);
        chk("dyn_wait", f2 - f1, 32'h0);
        chk("dyn_len", f1, ((c == 0) ? 1 : c) + 1);
        d = (i == 1) ? area12_cas_cycles_reg : area3_cas_cycles_reg;
        chk("cas", d, (c == 0) ? 1 : c);
      end
    end
    results();
  end
endmodule
`default_nettype wire
